// *** bppwr_pkg.sv ***
// Register map, reset values and field positions of the port block
package bppwr_pkg;
   localparam int NUM_PORTS = 4;
   localparam int PORT_W = 8;
   localparam int ADDR_W = 8;
   localparam int BIT_IDX_W = 3;

   // Port index within the packed per-port arrays
   localparam int PORT_FIRST = 0;
   localparam int PORT_SECOND = 1;
   localparam int PORT_THIRD = 2;
   localparam int PORT_FOURTH = 3;

   // Data-memory locations of the registers
   localparam logic [ADDR_W-1:0] OFS_FIRST_WAKE = 8'h00;
   localparam logic [NUM_PORTS-1:0][ADDR_W-1:0] OFS_PULL = {8'h0A, 8'h07, 8'h04, 8'h01};
   localparam logic [NUM_PORTS-1:0][ADDR_W-1:0] OFS_DIR = {8'h0B, 8'h08, 8'h05, 8'h02};
   localparam logic [NUM_PORTS-1:0][ADDR_W-1:0] OFS_DATA = {8'h0C, 8'h09, 8'h06, 8'h03};
   localparam logic [ADDR_W-1:0] OFS_REMAP = 8'h0D;

   // Reset values
   localparam logic [PORT_W-1:0] RST_WAKE = 8'h00;
   localparam logic [PORT_W-1:0] RST_PULL = 8'h00;
   localparam logic [PORT_W-1:0] RST_DIR = 8'hFF;
   localparam logic [PORT_W-1:0] RST_DATA = 8'hFF;
   localparam logic [3:0] RST_REMAP = 4'h0;

   // Implemented bits per port
   localparam logic [PORT_W-1:0] MASK_FULL = 8'hFF;
   localparam logic [PORT_W-1:0] MASK_SECOND_SMALL = 8'h3F;
   localparam logic [PORT_W-1:0] MASK_FOURTH = 8'h03;
   localparam logic [PORT_W-1:0] MASK_NONE = 8'h00;

   // Remap register fields (only the upper nibble exists)
   localparam int REMAP_LSB = 4;
   localparam int REMAP_W = 4;
   localparam int SEL_IRQ1 = 3;
   localparam int SEL_IRQ0 = 2;
   localparam int SEL_TIMER_CLK_IN1 = 1;
   localparam int SEL_TIMER_CLK_IN0 = 0;

   // Pin bits used by the remap selections
   localparam int PIN_B0 = 0;
   localparam int PIN_C1 = 1;
   localparam int PIN_A2 = 2;
   localparam int PIN_C0 = 0;
   localparam int PIN_C3 = 3;
   localparam int PIN_A6 = 6;
   localparam int PIN_C2 = 2;
endpackage : bppwr_pkg

// *** bppwr_gpio.sv ***
// Four-port bidirectional I/O block with pull-high, wake-up and pin remap
`timescale 1ns/1ns

// Function
// - Port reads sample pin level at read strobe
// - Output latch holds until rewritten
// - Pull-high only on inputs with bit set
// - Pull-high bits per pin, reset zero
// - Falling edge on enabled pin wakes device
// - Wake enable bit per first-port pin, reset zero
// - Direction bit one makes readable input
// - Direction zero drives latch; change anytime
// - Output pin reads return latch contents
// - Direction bits reset to one
// - Unimplemented bits ignore writes, read zero
// - Fourth port two bits; second six or eight
// - Remap bit7 routes irq1 B0 or C1
// - Remap bit6 routes irq0 A2 or C0
// - Remap bits5/4 route timer clock pins
// - Shared pin conflicts resolved by fixed priority
// - Registers at fixed data-memory addresses
// - Data latches reset high
// - Bit set/clear does read-modify-write
module bppwr_gpio
   import bppwr_pkg::*;
#(
   parameter bit SMALL_VARIANT = 1'b0,
   parameter bit HAS_FOURTH_PORT = 1'b1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] memAddr,
   input wire logic memWr,
   input wire logic [PORT_W-1:0] memWrData,
   input wire logic memRd,
   input wire logic bitSet,
   input wire logic bitClr,
   input wire logic [BIT_IDX_W-1:0] bitIdx,
   output logic [PORT_W-1:0] memRdData,
   input wire logic lowPowerMode,
   output logic wakeReq,
   input wire logic [PORT_W-1:0] firstPortIn,
   output logic [PORT_W-1:0] firstPortOut,
   output logic [PORT_W-1:0] firstPortOe,
   output logic [PORT_W-1:0] firstPortPullEn,
   input wire logic [PORT_W-1:0] secondPortIn,
   output logic [PORT_W-1:0] secondPortOut,
   output logic [PORT_W-1:0] secondPortOe,
   output logic [PORT_W-1:0] secondPortPullEn,
   input wire logic [PORT_W-1:0] thirdPortIn,
   output logic [PORT_W-1:0] thirdPortOut,
   output logic [PORT_W-1:0] thirdPortOe,
   output logic [PORT_W-1:0] thirdPortPullEn,
   input wire logic [PORT_W-1:0] fourthPortIn,
   output logic [PORT_W-1:0] fourthPortOut,
   output logic [PORT_W-1:0] fourthPortOe,
   output logic [PORT_W-1:0] fourthPortPullEn,
   input wire logic [NUM_PORTS*PORT_W-1:0] periphOe,
   input wire logic [NUM_PORTS*PORT_W-1:0] periphOut,
   output logic extIrqIn0,
   output logic extIrqIn1,
   output logic timerClkIn0,
   output logic timerClkIn1
);

   function automatic logic [PORT_W-1:0] implMask(input int p);
      if (p == PORT_SECOND && SMALL_VARIANT) begin
         return MASK_SECOND_SMALL;
      end else if (p == PORT_FOURTH) begin
         return HAS_FOURTH_PORT ? MASK_FOURTH : MASK_NONE;
      end else begin
         return MASK_FULL;
      end
   endfunction : implMask

   logic [NUM_PORTS-1:0][PORT_W-1:0] padIn;
   logic [NUM_PORTS-1:0][PORT_W-1:0] sync1Q;
   logic [NUM_PORTS-1:0][PORT_W-1:0] sync2Q;
   logic [PORT_W-1:0] firstPrevQ;
   logic [NUM_PORTS-1:0][PORT_W-1:0] dataQ;
   logic [NUM_PORTS-1:0][PORT_W-1:0] dirQ;
   logic [NUM_PORTS-1:0][PORT_W-1:0] pullQ;
   logic [NUM_PORTS-1:0][PORT_W-1:0] portView;
   logic [NUM_PORTS-1:0][PORT_W-1:0] padOut;
   logic [NUM_PORTS-1:0][PORT_W-1:0] padOe;
   logic [NUM_PORTS-1:0][PORT_W-1:0] padPull;
   logic [NUM_PORTS-1:0][PORT_W-1:0] implBits;
   logic [PORT_W-1:0] wakeEnQ;
   logic [REMAP_W-1:0] remapQ;
   logic [PORT_W-1:0] wakeFall;
   logic wrHit;
   logic [PORT_W-1:0] wrVal;
   logic [PORT_W-1:0] rmwBase;

   assign padIn = {fourthPortIn, thirdPortIn, secondPortIn, firstPortIn};

   // Implemented-bit mask per port, fixed by the variant parameters
   generate
      for (genvar p = 0; p < NUM_PORTS; p++) begin : g_impl
         assign implBits[p] = implMask(p);
      end
   endgenerate

   // Two-stage synchroniser on every pin input
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1Q <= '0;
         sync2Q <= '0;
      end else begin
         sync1Q <= padIn;
         sync2Q <= sync1Q;
      end
   end

   // Value software sees at each port data location
   generate
      for (genvar p = 0; p < NUM_PORTS; p++) begin : g_view
         assign portView[p] = ((dirQ[p] & sync2Q[p]) | (~dirQ[p] & dataQ[p]))
            & implMask(p);
      end
   endgenerate

   function automatic logic [PORT_W-1:0] readValue(input logic [ADDR_W-1:0] a);
      logic [PORT_W-1:0] v;
      v = '0;
      if (a == OFS_FIRST_WAKE) begin
         v = wakeEnQ;
      end else if (a == OFS_REMAP) begin
         v = {remapQ, {REMAP_LSB{1'b0}}};
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (a == OFS_DATA[p]) begin
               v = portView[p];
            end else if (a == OFS_DIR[p]) begin
               v = dirQ[p];
            end else if (a == OFS_PULL[p]) begin
               v = pullQ[p];
            end
         end
      end
      return v;
   endfunction : readValue

   // Bit instructions read the whole location, alter one bit, write all back
   always_comb begin
      rmwBase = readValue(memAddr);
      wrHit = memWr | bitSet | bitClr;
      if (bitSet) begin
         wrVal = rmwBase | (PORT_W'(1) << bitIdx);
      end else if (bitClr) begin
         wrVal = rmwBase & ~(PORT_W'(1) << bitIdx);
      end else begin
         wrVal = memWrData;
      end
   end

   // Read data captured on the read strobe, not latched from the pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         memRdData <= '0;
      end else if (memRd) begin
         memRdData <= readValue(memAddr);
      end
   end

   generate
      for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               dataQ[p] <= RST_DATA & implMask(p);
            end else if (wrHit && memAddr == OFS_DATA[p]) begin
               dataQ[p] <= wrVal & implMask(p);
            end
         end

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               dirQ[p] <= RST_DIR & implMask(p);
            end else if (wrHit && memAddr == OFS_DIR[p]) begin
               dirQ[p] <= wrVal & implMask(p);
            end
         end

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               pullQ[p] <= RST_PULL;
            end else if (wrHit && memAddr == OFS_PULL[p]) begin
               pullQ[p] <= wrVal & implMask(p);
            end
         end

         // Peripheral output takes priority over the port latch
         for (genvar b = 0; b < PORT_W; b++) begin : g_pin
            always_comb begin
               if (periphOe[p*PORT_W+b]) begin
                  padOut[p][b] = periphOut[p*PORT_W+b];
                  padOe[p][b] = implBits[p][b];
               end else begin
                  padOut[p][b] = dataQ[p][b];
                  padOe[p][b] = ~dirQ[p][b] & implBits[p][b];
               end
            end
         end
         assign padPull[p] = pullQ[p] & dirQ[p] & ~padOe[p];
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wakeEnQ <= RST_WAKE;
      end else if (wrHit && memAddr == OFS_FIRST_WAKE) begin
         wakeEnQ <= wrVal;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         remapQ <= RST_REMAP;
      end else if (wrHit && memAddr == OFS_REMAP) begin
         remapQ <= wrVal[PORT_W-1:REMAP_LSB];
      end
   end

   // Wake-up edge detect on the synchronised first port
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         firstPrevQ <= '0;
      end else begin
         firstPrevQ <= sync2Q[PORT_FIRST];
      end
   end

   assign wakeFall = firstPrevQ & ~sync2Q[PORT_FIRST] & wakeEnQ;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wakeReq <= 1'b0;
      end else begin
         wakeReq <= lowPowerMode && (|wakeFall);
      end
   end

   // Remapped peripheral inputs
   assign extIrqIn1 = remapQ[SEL_IRQ1] ? sync2Q[PORT_THIRD][PIN_C1]
      : sync2Q[PORT_SECOND][PIN_B0];
   assign extIrqIn0 = remapQ[SEL_IRQ0] ? sync2Q[PORT_THIRD][PIN_C0]
      : sync2Q[PORT_FIRST][PIN_A2];
   assign timerClkIn1 = remapQ[SEL_TIMER_CLK_IN1] ? sync2Q[PORT_THIRD][PIN_C3]
      : sync2Q[PORT_SECOND][PIN_B0];
   assign timerClkIn0 = remapQ[SEL_TIMER_CLK_IN0] ? sync2Q[PORT_THIRD][PIN_C2]
      : sync2Q[PORT_FIRST][PIN_A6];

   assign firstPortOut = padOut[PORT_FIRST];
   assign firstPortOe = padOe[PORT_FIRST];
   assign firstPortPullEn = padPull[PORT_FIRST];
   assign secondPortOut = padOut[PORT_SECOND];
   assign secondPortOe = padOe[PORT_SECOND];
   assign secondPortPullEn = padPull[PORT_SECOND];
   assign thirdPortOut = padOut[PORT_THIRD];
   assign thirdPortOe = padOe[PORT_THIRD];
   assign thirdPortPullEn = padPull[PORT_THIRD];
   assign fourthPortOut = padOut[PORT_FOURTH];
   assign fourthPortOe = padOe[PORT_FOURTH];
   assign fourthPortPullEn = padPull[PORT_FOURTH];

   // Checks
   a_pull_gate: assert property (@(posedge clk) disable iff (!rst_n)
      (!dirQ[PORT_THIRD][0]) |-> !thirdPortPullEn[0])
      else $error("pull-high active on an output pin");

   a_read_output_latch: assert property (@(posedge clk) disable iff (!rst_n)
      (memRd && memAddr == OFS_DATA[PORT_FIRST] && !dirQ[PORT_FIRST][0])
      |=> memRdData[0] == $past(dataQ[PORT_FIRST][0]))
      else $error("output pin read did not return latch");

   a_read_input_pin: assert property (@(posedge clk) disable iff (!rst_n)
      (memRd && memAddr == OFS_DATA[PORT_SECOND] && dirQ[PORT_SECOND][0])
      |=> memRdData[0] == $past(sync2Q[PORT_SECOND][0]))
      else $error("input pin read did not return pin level");

   a_latch_holds: assert property (@(posedge clk) disable iff (!rst_n)
      !(wrHit && memAddr == OFS_DATA[PORT_THIRD]) |=> $stable(dataQ[PORT_THIRD]))
      else $error("output latch changed without a write");

   a_wake_fall: assert property (@(posedge clk) disable iff (!rst_n)
      (lowPowerMode && wakeEnQ[1] && firstPrevQ[1] && !sync2Q[PORT_FIRST][1])
      |=> wakeReq)
      else $error("enabled falling edge did not wake");

   a_wake_awake: assert property (@(posedge clk) disable iff (!rst_n)
      !$past(lowPowerMode) |-> !wakeReq)
      else $error("wake request outside low-power state");

   a_fourth_unimpl: assert property (@(posedge clk) disable iff (!rst_n)
      (memRd && memAddr == OFS_DIR[PORT_FOURTH]) |=> memRdData[PORT_W-1:2] == '0)
      else $error("unimplemented fourth-port bits read nonzero");

   a_remap_irq1: assert property (@(posedge clk) disable iff (!rst_n)
      remapQ[SEL_IRQ1] |-> extIrqIn1 == sync2Q[PORT_THIRD][PIN_C1])
      else $error("irq1 not taken from remapped pin");

   a_rmw_set: assert property (@(posedge clk) disable iff (!rst_n)
      (bitSet && !memWr && memAddr == OFS_DIR[PORT_FIRST] && bitIdx == 3'h2)
      |=> dirQ[PORT_FIRST][2] && dirQ[PORT_FIRST][1] == $past(dirQ[PORT_FIRST][1]))
      else $error("bit set did not read-modify-write");

   a_output_drive: assert property (@(posedge clk) disable iff (!rst_n)
      (!dirQ[PORT_FIRST][4] && !periphOe[4]) |-> firstPortOe[4]
      && firstPortOut[4] == dataQ[PORT_FIRST][4])
      else $error("output pin not driven from latch");

   a_periph_priority: assert property (@(posedge clk) disable iff (!rst_n)
      periphOe[PORT_SECOND*PORT_W] |-> secondPortOe[0]
      && secondPortOut[0] == periphOut[PORT_SECOND*PORT_W])
      else $error("peripheral did not override port latch");

   a_pull_driven: assert property (@(posedge clk) disable iff (!rst_n)
      periphOe[0] |-> !firstPortPullEn[0])
      else $error("pull-high active on a driven pin");

   a_input_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
      (dirQ[PORT_THIRD][5] && !periphOe[PORT_THIRD*PORT_W+5]) |-> !thirdPortOe[5])
      else $error("input pin is driven");

   a_dir_write: assert property (@(posedge clk) disable iff (!rst_n)
      (memWr && !bitSet && !bitClr && memAddr == OFS_DIR[PORT_SECOND])
      |=> dirQ[PORT_SECOND] == ($past(memWrData) & implBits[PORT_SECOND]))
      else $error("direction write did not land");

   a_pull_write: assert property (@(posedge clk) disable iff (!rst_n)
      (memWr && !bitSet && !bitClr && memAddr == OFS_PULL[PORT_THIRD])
      |=> pullQ[PORT_THIRD] == ($past(memWrData) & implBits[PORT_THIRD]))
      else $error("pull-high write did not land");

   a_fourth_data: assert property (@(posedge clk) disable iff (!rst_n)
      (memWr && memAddr == OFS_DATA[PORT_FOURTH])
      |=> dataQ[PORT_FOURTH][PORT_W-1:2] == '0)
      else $error("unimplemented fourth-port latch bits set");

   a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n)
      (memRd && memAddr > OFS_REMAP) |=> memRdData == '0)
      else $error("unmapped location read nonzero");

   a_remap_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (memRd && memAddr == OFS_REMAP) |=> memRdData[REMAP_LSB-1:0] == '0)
      else $error("unimplemented remap bits read nonzero");

   a_wake_en_read: assert property (@(posedge clk) disable iff (!rst_n)
      (memRd && memAddr == OFS_FIRST_WAKE) |=> memRdData == $past(wakeEnQ))
      else $error("wake enable read mismatch");

   a_wake_needs_en: assert property (@(posedge clk) disable iff (!rst_n)
      (wakeFall == '0) |=> !wakeReq)
      else $error("wake request without enabled falling edge");

   a_remap_irq0: assert property (@(posedge clk) disable iff (!rst_n)
      remapQ[SEL_IRQ0] |-> extIrqIn0 == sync2Q[PORT_THIRD][PIN_C0])
      else $error("irq0 not taken from remapped pin");

   a_remap_timer_clk_in0: assert property (@(posedge clk) disable iff (!rst_n)
      !remapQ[SEL_TIMER_CLK_IN0] |-> timerClkIn0 == sync2Q[PORT_FIRST][PIN_A6])
      else $error("timer clock 0 not taken from default pin");

   a_remap_timer_clk_in1: assert property (@(posedge clk) disable iff (!rst_n)
      remapQ[SEL_TIMER_CLK_IN1] |-> timerClkIn1 == sync2Q[PORT_THIRD][PIN_C3])
      else $error("timer clock 1 not taken from remapped pin");

   c_wake: cover property (@(posedge clk) disable iff (!rst_n) wakeReq);
   c_rmw: cover property (@(posedge clk) disable iff (!rst_n)
      bitClr && memAddr == OFS_DATA[PORT_FIRST]);
   c_remap: cover property (@(posedge clk) disable iff (!rst_n) remapQ == 4'hF);
   c_periph: cover property (@(posedge clk) disable iff (!rst_n)
      periphOe[0] && firstPortOe[0]);
   c_bit_set: cover property (@(posedge clk) disable iff (!rst_n)
      bitSet && memAddr == OFS_DIR[PORT_FIRST]);

endmodule : bppwr_gpio

// *** bppwr_pins.sv ***
// External circuitry model: drives input pins, resolves pads, pull-highs and floating lines
`timescale 1ns/1ns
module bppwr_pins (
   input wire logic clk,
   input wire logic [31:0] drvEn,
   input wire logic [31:0] drvVal,
   input wire logic [31:0] padOe,
   input wire logic [31:0] padOut,
   input wire logic [31:0] padPull,
   output logic [31:0] pinLvl
);
   logic [31:0] flutter;
   initial flutter = 32'h5555_5555;
   always @(posedge clk) flutter <= ~flutter;
   // A released line with no pull-high must not settle to a lucky constant
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         if (padOe[i]) pinLvl[i] = padOut[i];
         else if (drvEn[i]) pinLvl[i] = drvVal[i];
         else if (padPull[i]) pinLvl[i] = 1'b1;
         else pinLvl[i] = flutter[i];
      end
   end
endmodule : bppwr_pins

// *** test_bidir_port_pullup_wake_remap.sv ***
// Self-checking bench for the four-port I/O block against a byte-level model
`timescale 1ns/1ns
module test_bidir_port_pullup_wake_remap;
   import bppwr_pkg::*;
   logic clk, rst_n, memWr, memRd, bitSet, bitClr, lowPowerMode;
   logic [7:0] memAddr, memWrData, memRdData, w;
   logic [2:0] bitIdx;
   logic wakeReq, extIrqIn0, extIrqIn1, timerClkIn0, timerClkIn1;
   logic [31:0] pin, oe, out, pull, drvEn, drvVal, pOe, pOut;
   logic [7:0] mdl [16];
   logic [7:0] msk [16];
   int n_fail, tests_run, a, k, lp;

   bppwr_gpio DUT (.clk(clk), .rst_n(rst_n), .memAddr(memAddr), .memWr(memWr),
      .memWrData(memWrData), .memRd(memRd), .bitSet(bitSet), .bitClr(bitClr),
      .bitIdx(bitIdx), .memRdData(memRdData), .lowPowerMode(lowPowerMode), .wakeReq(wakeReq),
      .firstPortIn(pin[7:0]), .firstPortOut(out[7:0]), .firstPortOe(oe[7:0]),
      .firstPortPullEn(pull[7:0]), .secondPortIn(pin[15:8]), .secondPortOut(out[15:8]),
      .secondPortOe(oe[15:8]), .secondPortPullEn(pull[15:8]), .thirdPortIn(pin[23:16]),
      .thirdPortOut(out[23:16]), .thirdPortOe(oe[23:16]), .thirdPortPullEn(pull[23:16]),
      .fourthPortIn(pin[31:24]), .fourthPortOut(out[31:24]), .fourthPortOe(oe[31:24]),
      .fourthPortPullEn(pull[31:24]), .periphOe(pOe), .periphOut(pOut),
      .extIrqIn0(extIrqIn0), .extIrqIn1(extIrqIn1), .timerClkIn0(timerClkIn0),
      .timerClkIn1(timerClkIn1));

   bppwr_pins far (.clk(clk), .drvEn(drvEn), .drvVal(drvVal), .padOe(oe), .padOut(out),
      .padPull(pull), .pinLvl(pin));

   // Level on the pins of a port: peripheral override, far-side drive or latch
   function automatic logic [7:0] lvl(input int p);
      logic [7:0] e, dr;
      e = pOe[p*8+:8];
      dr = mdl[3*p+2];
      return (e & pOut[p*8+:8]) | (~e & ((dr & drvVal[p*8+:8]) | (~dr & mdl[3*p+3])));
   endfunction : lvl

   // Port view of a location: pin level on inputs, latch on outputs
   function automatic logic [7:0] view(input int adr);
      int p;
      p = adr / 3 - 1;
      if (adr % 3 == 0 && adr > 0 && adr < 13) begin
         return ((mdl[adr] & ~mdl[adr-1]) | (lvl(p) & mdl[adr-1])) & msk[adr];
      end
      return mdl[adr];
   endfunction : view

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wr(input int adr, input logic [7:0] d, input int op);
      logic [7:0] v;
      v = view(adr);
      if (op == 0) v = d;
      else if (op == 1) v[d[2:0]] = 1'b1;
      else v[d[2:0]] = 1'b0;
      mdl[adr] = v & msk[adr];
      @(posedge clk);
      memAddr <= 8'(adr);
      memWrData <= d;
      bitIdx <= d[2:0];
      memWr <= (op == 0);
      bitSet <= (op == 1);
      bitClr <= (op == 2);
      @(posedge clk);
      memWr <= 1'b0;
      bitSet <= 1'b0;
      bitClr <= 1'b0;
   endtask : wr

   task automatic rd(input int adr);
      @(posedge clk);
      memAddr <= 8'(adr);
      memRd <= 1'b1;
      @(posedge clk);
      memRd <= 1'b0;
      #1;
   endtask : rd

   task automatic pads();
      logic [31:0] m, d, o, pl;
      logic [3:0] r;
      logic [7:0] la, lb, lc;
      for (int p = 0; p < 4; p++) begin
         m[p*8+:8] = msk[3*p+3];
         d[p*8+:8] = mdl[3*p+2];
         o[p*8+:8] = mdl[3*p+3];
         pl[p*8+:8] = mdl[3*p+1];
      end
      la = lvl(0);
      lb = lvl(1);
      lc = lvl(2);
      r[3] = mdl[13][7] ? lc[1] : lb[0];
      r[2] = mdl[13][6] ? lc[0] : la[2];
      r[1] = mdl[13][5] ? lc[3] : lb[0];
      r[0] = mdl[13][4] ? lc[2] : la[6];
      chk("oe", (~d | pOe) & m, oe & m);
      chk("out", ((pOe & pOut) | (~pOe & o)) & m, out & m);
      chk("pull", pl & d & ~pOe & m, pull & m);
      chk("remap", r, {extIrqIn1, extIrqIn0, timerClkIn1, timerClkIn0});
   endtask : pads

   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 16; i++) mdl[i] = (i % 3 != 1 && i % 13 != 0) ? msk[i] : 8'h00;
      for (int i = 0; i < 16; i++) begin
         rd(i);
         chk("reset read", view(i), memRdData);
      end
      pads();
      $display("Test reset values done");
   endtask : do_reset

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      close_out();
   end

   initial begin
      rst_n = 1'b0;
      {memWr, memRd, bitSet, bitClr, lowPowerMode} = 5'h00;
      memAddr = 8'h00;
      memWrData = 8'h00;
      bitIdx = 3'h0;
      drvEn = 32'hFFFF_FFFF;
      drvVal = 32'h0F0F_0F0F;
      pOe = 32'h0000_0000;
      pOut = 32'h0000_0000;
      n_fail = 0;
      tests_run = 0;
      for (int i = 0; i < 16; i++) msk[i] = (i < 10) ? 8'hFF : (i < 13) ? 8'h03 : 8'h00;
      msk[13] = 8'hF0;
      void'($urandom(46045));
      do_reset();
      repeat (300) begin
         @(posedge clk);
         drvVal <= $urandom;
         pOe <= $urandom & $urandom;
         pOut <= $urandom;
         repeat (3) @(posedge clk);
         a = $urandom_range(0, 15);
         wr(a, 8'($urandom), $urandom_range(0, 2));
         repeat (3) @(posedge clk);
         rd(a);
         chk("read", view(a), memRdData);
         pads();
      end
      $display("Test random access done");
      pOe <= 32'h0000_0000;
      wr(2, 8'h02, 1);
      rd(2);
      chk("bit set", view(2), memRdData);
      wr(1, 8'hA5, 0);
      wr(2, 8'hFF, 0);
      drvEn <= 32'hFFFF_FF00;
      repeat (4) @(posedge clk);
      rd(3);
      chk("pulled", 8'hA5, memRdData & 8'hA5);
      drvEn <= 32'hFFFF_FFFF;
      $display("Test pull-high done");
      for (int i = 0; i < 24; i++) begin
         w = 8'($urandom);
         lp = $urandom_range(0, 1);
         wr(0, w, 0);
         lowPowerMode <= lp[0];
         drvVal[7:0] <= 8'hFF;
         repeat (5) @(posedge clk);
         drvVal[i % 8] <= 1'b0;
         k = 0;
         repeat (6) begin
            @(posedge clk);
            #1;
            k += (wakeReq === 1'b1);
         end
         chk("wake", (lp == 1 && w[i % 8]) ? 1 : 0, k);
      end
      lowPowerMode <= 1'b0;
      $display("Test wake-up done");
      do_reset();
      close_out();
   end
endmodule : test_bidir_port_pullup_wake_remap
